// ### pkg/tgc_pkg.sv
/*
 * Shared constants for the transceiver global control register bank:
 * register indices, field positions, reset values and MDIO frame codes.
 * Assumes a clause-22 style management frame with 5-bit port and
 * register addresses and 16-bit data.
 */
package tgc_pkg;
    localparam int DATA_W = 16;
    localparam int ADDR_W = 5;
    localparam int PAIR_COUNT = 4;

    // Register indices on the management bus
    localparam logic [4:0] REG_GLOBAL = 5'h11;
    localparam logic [4:0] REG_PAIR_AB = 5'h12;
    localparam logic [4:0] REG_PAIR_CD = 5'h13;
    localparam logic [4:0] REG_PAIR_EF = 5'h14;
    localparam logic [4:0] REG_PAIR_GH = 5'h15;

    // Global control word fields
    localparam int BIT_TX_CLK_MODE = 15;
    localparam int BIT_VIOL_REPORT = 14;
    localparam int BIT_OUT_ENABLE = 9;
    localparam int BIT_COMMA_DETECT_ENABLE = 8;
    localparam int BIT_LINE_CODE = 7;
    localparam int BIT_MODE_OVERRIDE = 6;
    localparam int MODE_LSB = 4;
    localparam int BIT_SOFT_RESET = 3;

    // Pair word fields
    localparam int EMPH_LSB = 10;
    localparam int BIT_EDGE_OVR = 9;
    localparam int IDLE_W = 9;
    localparam int IDLE_CTRL_BIT = 8;

    // Reset values and writable masks
    localparam logic [15:0] GLOBAL_RESET = 16'h4380;
    localparam logic [15:0] GLOBAL_WMASK = 16'hC3F0;
    localparam logic [15:0] PAIR_WMASK = 16'h0FFF;
    localparam logic [15:0] PAIR_RESET_FIRST = 16'h0DBC;
    localparam logic [15:0] PAIR_RESET_SECOND = 16'h0C50;
    localparam logic [8:0] IDLE_K28_5 = 9'h1BC;
    localparam logic [8:0] IDLE_D16_2 = 9'h050;

    // Preemphasis levels
    localparam logic [1:0] EMPH_NONE = 2'h0;
    localparam logic [1:0] EMPH_LOW = 2'h1;
    localparam logic [1:0] EMPH_MID = 2'h2;
    localparam logic [1:0] EMPH_HIGH = 2'h3;

    // Management frame
    localparam logic [5:0] PRE_LEN = 6'h20;
    localparam logic [1:0] OP_WRITE = 2'h1;
    localparam logic [1:0] OP_READ = 2'h2;
    localparam logic [3:0] ADDR_LAST = 4'h9;
    localparam logic [3:0] DATA_LAST = 4'hF;

    // Positions in the synchronised terminal vector
    localparam int PIN_TX_CLK = 0;
    localparam int PIN_VIOL = 1;
    localparam int PIN_ENABLE = 2;
    localparam int PIN_CODE = 3;
    localparam int PIN_MODE_LSB = 4;
    localparam int PIN_EMPH_LSB = 6;
    localparam int PIN_W = 8;

    typedef enum logic [2:0] {
        TGC_PRE = 3'b000,
        TGC_START = 3'b001,
        TGC_OP = 3'b010,
        TGC_ADDR = 3'b011,
        TGC_TA = 3'b100,
        TGC_DATA = 3'b101
    } tgc_mdio_state_t;
endpackage

// ### pkg/tgc_mgmt_if.sv
/*
 * Register access carrier between the management frame engine and the
 * register bank. Everything here lives in the management clock domain.
 */
interface tgc_mgmt_if;
    logic wr_stb;
    logic [4:0] addr;
    logic [15:0] wdata;
    logic [15:0] rdata;

    modport slave (output wr_stb, output addr, output wdata, input rdata);
    modport regs (input wr_stb, input addr, input wdata, output rdata);
endinterface

// ### rtl/tgc_sync.sv
/*
 * Three-stage synchroniser for a vector of slow levels. A bit's output
 * changes only when the second and third stages agree.
 * Assumes each bit is a level that stays put for several destination clocks.
 */
module tgc_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RESET_VAL = '0
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Data
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;

    // Capture chain
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s1_q <= RESET_VAL;
            s2_q <= RESET_VAL;
            s3_q <= RESET_VAL;
        end else begin
            s1_q <= d;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // Accept a bit once the last two stages agree
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            q <= RESET_VAL;
        end else begin
            q <= (s2_q & s3_q) | (q & (s2_q | s3_q));
        end
    end
endmodule

// ### rtl/tgc_mdio_slave.sv
/*
 * Management frame engine: decodes preamble, start, opcode, port and
 * register address, turnaround and data, sampling mdio_i on rising mdc.
 * Assumes the station drives mdio on falling mdc, clear of the rising sampling edge.
 */
module tgc_mdio_slave (
    // Management clock and reset
    input wire logic mdc,
    input wire logic mdc_rst_n,
    // Serial data pin
    input wire logic mdio_i,
    output logic mdio_o,
    output logic mdio_oe,
    // Port address
    input wire logic [4:0] port_address,
    // Register side
    tgc_mgmt_if.slave mgmt
);
    tgc_pkg::tgc_mdio_state_t state_q;
    logic [5:0] ones_q;
    logic [3:0] cnt_q;
    logic [15:0] sh_q;
    logic [1:0] op_q;
    logic sel_q;
    logic [9:0] addr_full;

    assign addr_full = {sh_q[8:0], mdio_i};

    // Frame decode and serial drive
    always_ff @(posedge mdc) begin
        if (!mdc_rst_n) begin
            state_q <= tgc_pkg::TGC_PRE;
            ones_q <= '0;
            cnt_q <= '0;
            sh_q <= '0;
            op_q <= '0;
            sel_q <= 1'b0;
            mdio_o <= 1'b0;
            mdio_oe <= 1'b0;
            mgmt.wr_stb <= 1'b0;
            mgmt.addr <= '0;
            mgmt.wdata <= '0;
        end else begin
            mgmt.wr_stb <= 1'b0;
            case (state_q)
                tgc_pkg::TGC_PRE: begin
                    if (mdio_i) begin
                        if (ones_q != tgc_pkg::PRE_LEN) ones_q <= ones_q + 6'h01;
                    end else begin
                        if (ones_q == tgc_pkg::PRE_LEN) state_q <= tgc_pkg::TGC_START;
                        ones_q <= '0;
                    end
                end
                tgc_pkg::TGC_START: begin
                    cnt_q <= '0;
                    state_q <= mdio_i ? tgc_pkg::TGC_OP : tgc_pkg::TGC_PRE;
                end
                tgc_pkg::TGC_OP: begin
                    op_q <= {op_q[0], mdio_i};
                    cnt_q <= cnt_q + 4'h1;
                    if (cnt_q != 4'h0) begin
                        cnt_q <= '0;
                        state_q <= tgc_pkg::TGC_ADDR;
                    end
                end
                tgc_pkg::TGC_ADDR: begin
                    sh_q <= {sh_q[14:0], mdio_i};
                    cnt_q <= cnt_q + 4'h1;
                    if (cnt_q == tgc_pkg::ADDR_LAST) begin
                        cnt_q <= '0;
                        sel_q <= (addr_full[9:5] == port_address) &&
                                 (op_q == tgc_pkg::OP_READ || op_q == tgc_pkg::OP_WRITE);
                        mgmt.addr <= addr_full[4:0];
                        state_q <= tgc_pkg::TGC_TA;
                    end
                end
                tgc_pkg::TGC_TA: begin
                    cnt_q <= cnt_q + 4'h1;
                    if (sel_q && op_q == tgc_pkg::OP_READ) begin
                        mdio_oe <= 1'b1;
                        mdio_o <= (cnt_q != 4'h0) ? mgmt.rdata[15] : 1'b0;
                        sh_q <= {mgmt.rdata[14:0], 1'b0};
                    end
                    if (cnt_q != 4'h0) begin
                        cnt_q <= '0;
                        state_q <= tgc_pkg::TGC_DATA;
                    end
                end
                tgc_pkg::TGC_DATA: begin
                    cnt_q <= cnt_q + 4'h1;
                    if (op_q == tgc_pkg::OP_READ) begin
                        mdio_o <= sh_q[15];
                        sh_q <= {sh_q[14:0], 1'b0};
                    end else begin
                        sh_q <= {sh_q[14:0], mdio_i};
                    end
                    if (cnt_q == tgc_pkg::DATA_LAST) begin
                        mdio_oe <= 1'b0;
                        mdio_o <= 1'b0;
                        mgmt.wdata <= {sh_q[14:0], mdio_i};
                        mgmt.wr_stb <= sel_q && (op_q == tgc_pkg::OP_WRITE);
                        state_q <= tgc_pkg::TGC_PRE;
                    end
                end
                default: state_q <= tgc_pkg::TGC_PRE;
            endcase
        end
    end

    // Drive window is the second turnaround bit plus sixteen data bits
    localparam logic [4:0] OE_CYCLES = 5'h11;
    logic [4:0] oe_len_q;

    // Helper count of consecutive driven cycles, so the window is not unrolled
    always_ff @(posedge mdc) begin
        if (!mdc_rst_n) begin
            oe_len_q <= '0;
        end else if (mdio_oe) begin
            oe_len_q <= oe_len_q + 5'h01;
        end else begin
            oe_len_q <= '0;
        end
    end

    // Turnaround drives a zero before the first data bit
    sequence s_read_ta;
        state_q == tgc_pkg::TGC_TA && cnt_q == 4'h0 && sel_q && op_q == tgc_pkg::OP_READ;
    endsequence
    sequence s_drive_end;
        !mdio_oe && oe_len_q == OE_CYCLES;
    endsequence
    a_read_turnaround: assert property (@(posedge mdc) disable iff (!mdc_rst_n)
        s_read_ta |=> (mdio_oe && !mdio_o) ##17 s_drive_end)
        else $error("read turnaround or data drive window wrong");
endmodule

// ### rtl/tgc_top.sv
/*
 * Global control register bank of an eight-channel serial transceiver.
 * Registers live on the management clock and are written over the
 * management serial pin; register words are copied into the core clock once a write toggle
 * passes a three-stage synchroniser, and all controls but comma detect are combined with the device terminals.
 * Assumes mdc runs while rst_n is held low so the register bank resets,
 * and that register words are quasi-static compared with the core clock.
 */
module tgc_top (
    // Core clock and reset terminal
    input wire logic clk,
    input wire logic rst_n,
    // Management link
    input wire logic mdc,
    input wire logic mdio_i,
    output logic mdio_o,
    output logic mdio_oe,
    input wire logic [4:0] port_address,
    // Device terminals
    input wire logic tx_clock_select_pin,
    input wire logic violation_report_pin,
    input wire logic device_enable_pin,
    input wire logic line_code_pin,
    input wire logic [1:0] mode_pin,
    input wire logic [1:0] global_emphasis_pin,
    // Datapath controls
    output logic tx_clock_individual_sel,
    output logic violation_report_enable,
    output logic parallel_out_enable,
    output logic comma_detect_enable,
    output logic line_code_enable,
    output logic [1:0] interface_mode,
    output logic datapath_reset,
    // Serial emphasis, pair AB in bits 1:0 up to GH in bits 7:6
    output logic [7:0] emphasis_level,
    output logic [3:0] emphasis_override,
    // Idle characters
    output logic [8:0] idle_char_first,
    output logic [8:0] idle_char_second,
    output logic [8:0] idle_char_first_alt,
    output logic [8:0] idle_char_second_alt,
    output logic [3:0] idle_is_control
);
    tgc_mgmt_if mgmt ();

    // Management domain state
    logic mdc_rst_n;
    logic [15:0] global_q;
    logic soft_reset_q;
    logic soft_toggle_q;
    logic word_toggle_q;
    logic [15:0] pair_q [tgc_pkg::PAIR_COUNT];
    logic [15:0] rdata_d;

    // Core domain state
    logic [tgc_pkg::PIN_W-1:0] pins_s;
    logic [15:0] global_s;
    logic [63:0] pair_s;
    logic soft_toggle_s;
    logic word_toggle_s;
    logic word_seen_q;
    logic word_load;
    logic soft_toggle_seen_q;
    logic soft_pulse;

    // Reset terminal carried into the management domain
    tgc_sync #(.W(1), .RESET_VAL(1'b0)) u_mdc_rst (
        .clk(mdc),
        .rst_n(rst_n),
        .d(rst_n),
        .q(mdc_rst_n)
    );

    tgc_mdio_slave u_mdio (
        .mdc(mdc),
        .mdc_rst_n(mdc_rst_n),
        .mdio_i(mdio_i),
        .mdio_o(mdio_o),
        .mdio_oe(mdio_oe),
        .port_address(port_address),
        .mgmt(mgmt.slave)
    );

    // reserved ignore
    // Global word keeps writable bits only
    always_ff @(posedge mdc) begin
        if (!mdc_rst_n) begin
            global_q <= tgc_pkg::GLOBAL_RESET;
        end else if (mgmt.wr_stb && mgmt.addr == tgc_pkg::REG_GLOBAL) begin
            global_q <= mgmt.wdata & tgc_pkg::GLOBAL_WMASK;
        end
    end

    // Any register write flips this toggle to announce settled new words
    always_ff @(posedge mdc) begin
        if (!mdc_rst_n) begin
            word_toggle_q <= 1'b0;
        end else if (mgmt.wr_stb) begin
            word_toggle_q <= ~word_toggle_q;
        end
    end

    // self clearing bit
    // Soft reset bit lasts one management clock, toggle carries the event
    always_ff @(posedge mdc) begin
        if (!mdc_rst_n) begin
            soft_reset_q <= 1'b0;
            soft_toggle_q <= 1'b0;
        end else if (mgmt.wr_stb && mgmt.addr == tgc_pkg::REG_GLOBAL &&
                     mgmt.wdata[tgc_pkg::BIT_SOFT_RESET]) begin
            soft_reset_q <= 1'b1;
            soft_toggle_q <= ~soft_toggle_q;
        end else begin
            soft_reset_q <= 1'b0;
        end
    end

    // idle defaults
    // Pair words at consecutive indices, reset by position
    for (genvar p = 0; p < tgc_pkg::PAIR_COUNT; p++) begin : g_pair
        localparam logic [15:0] PAIR_RESET = (p % 2 == 0) ? tgc_pkg::PAIR_RESET_FIRST :
                                                            tgc_pkg::PAIR_RESET_SECOND;
        localparam logic [4:0] PAIR_ADDR = tgc_pkg::REG_PAIR_AB + 5'(p);
        always_ff @(posedge mdc) begin
            if (!mdc_rst_n) begin
                pair_q[p] <= PAIR_RESET;
            end else if (mgmt.wr_stb && mgmt.addr == PAIR_ADDR) begin
                pair_q[p] <= mgmt.wdata & tgc_pkg::PAIR_WMASK;
            end
        end
    end

    // reserved read zero
    // Read mux, unmapped indices read zero
    always_comb begin
        case (mgmt.addr)
            tgc_pkg::REG_GLOBAL: rdata_d = global_q |
                                 (16'(soft_reset_q) << tgc_pkg::BIT_SOFT_RESET);
            tgc_pkg::REG_PAIR_AB: rdata_d = pair_q[0];
            tgc_pkg::REG_PAIR_CD: rdata_d = pair_q[1];
            tgc_pkg::REG_PAIR_EF: rdata_d = pair_q[2];
            tgc_pkg::REG_PAIR_GH: rdata_d = pair_q[3];
            default: rdata_d = 16'h0000;
        endcase
    end
    assign mgmt.rdata = rdata_d;

    // Terminals into the core domain
    tgc_sync #(.W(tgc_pkg::PIN_W), .RESET_VAL('0)) u_pin_sync (
        .clk(clk),
        .rst_n(rst_n),
        .d({global_emphasis_pin, mode_pin, line_code_pin, device_enable_pin,
            violation_report_pin, tx_clock_select_pin}),
        .q(pins_s)
    );

    // Write announcement into the core domain
    tgc_sync #(.W(1), .RESET_VAL(1'b0)) u_word_sync (
        .clk(clk),
        .rst_n(rst_n),
        .d(word_toggle_q),
        .q(word_toggle_s)
    );

    // Edge of the synchronised write toggle
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            word_seen_q <= 1'b0;
        end else begin
            word_seen_q <= word_toggle_s;
        end
    end
    assign word_load = word_toggle_s ^ word_seen_q;

    // Whole words copied once the toggle arrives; one write per frame keeps them still
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            global_s <= tgc_pkg::GLOBAL_RESET;
            pair_s <= {tgc_pkg::PAIR_RESET_SECOND, tgc_pkg::PAIR_RESET_FIRST,
                       tgc_pkg::PAIR_RESET_SECOND, tgc_pkg::PAIR_RESET_FIRST};
        end else if (word_load) begin
            global_s <= global_q;
            pair_s <= {pair_q[3], pair_q[2], pair_q[1], pair_q[0]};
        end
    end

    // Soft reset event into the core domain
    tgc_sync #(.W(1), .RESET_VAL(1'b0)) u_soft_sync (
        .clk(clk),
        .rst_n(rst_n),
        .d(soft_toggle_q),
        .q(soft_toggle_s)
    );

    // Edge of the synchronised toggle
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            soft_toggle_seen_q <= 1'b0;
        end else begin
            soft_toggle_seen_q <= soft_toggle_s;
        end
    end
    assign soft_pulse = soft_toggle_s ^ soft_toggle_seen_q;

    // datapath reset
    // Terminal or soft reset clears the datapath; soft reset never touches the register bank
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            datapath_reset <= 1'b1;
        end else begin
            datapath_reset <= soft_pulse;
        end
    end

    // comma enable
    // Global controls, all but comma detect combined with the terminals
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            tx_clock_individual_sel <= 1'b0;
            violation_report_enable <= 1'b1;
            parallel_out_enable <= 1'b0;
            comma_detect_enable <= 1'b1;
            line_code_enable <= 1'b1;
        end else begin
            tx_clock_individual_sel <= global_s[tgc_pkg::BIT_TX_CLK_MODE] |
                                       pins_s[tgc_pkg::PIN_TX_CLK];
            violation_report_enable <= global_s[tgc_pkg::BIT_VIOL_REPORT] |
                                       pins_s[tgc_pkg::PIN_VIOL];
            parallel_out_enable <= global_s[tgc_pkg::BIT_OUT_ENABLE] &
                                   pins_s[tgc_pkg::PIN_ENABLE];
            comma_detect_enable <= global_s[tgc_pkg::BIT_COMMA_DETECT_ENABLE];
            line_code_enable <= global_s[tgc_pkg::BIT_LINE_CODE] | pins_s[tgc_pkg::PIN_CODE];
        end
    end

    // mode override
    // Interface mode from register field or terminals
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            interface_mode <= 2'h0;
        end else if (global_s[tgc_pkg::BIT_MODE_OVERRIDE]) begin
            interface_mode <= global_s[tgc_pkg::MODE_LSB +: 2];
        end else begin
            interface_mode <= pins_s[tgc_pkg::PIN_MODE_LSB +: 2];
        end
    end

    // emphasis select
    // Per pair: local level when overridden, else the global level
    for (genvar p = 0; p < tgc_pkg::PAIR_COUNT; p++) begin : g_emph
        always_ff @(posedge clk) begin
            if (!rst_n) begin
                emphasis_level[2*p +: 2] <= tgc_pkg::EMPH_HIGH;
                emphasis_override[p] <= 1'b0;
            end else begin
                emphasis_override[p] <= pair_s[16*p + tgc_pkg::BIT_EDGE_OVR];
                emphasis_level[2*p +: 2] <= pair_s[16*p + tgc_pkg::BIT_EDGE_OVR] ?
                                            pair_s[16*p + tgc_pkg::EMPH_LSB +: 2] :
                                            pins_s[tgc_pkg::PIN_EMPH_LSB +: 2];
            end
        end
    end

    // control flag split
    // Idle characters and their control flags
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            idle_char_first <= tgc_pkg::IDLE_K28_5;
            idle_char_second <= tgc_pkg::IDLE_D16_2;
            idle_char_first_alt <= tgc_pkg::IDLE_K28_5;
            idle_char_second_alt <= tgc_pkg::IDLE_D16_2;
            idle_is_control <= 4'h5;
        end else begin
            idle_char_first <= pair_s[0 +: tgc_pkg::IDLE_W];
            idle_char_second <= pair_s[16 +: tgc_pkg::IDLE_W];
            idle_char_first_alt <= pair_s[32 +: tgc_pkg::IDLE_W];
            idle_char_second_alt <= pair_s[48 +: tgc_pkg::IDLE_W];
            idle_is_control <= {pair_s[48 + tgc_pkg::IDLE_CTRL_BIT],
                                pair_s[32 + tgc_pkg::IDLE_CTRL_BIT],
                                pair_s[16 + tgc_pkg::IDLE_CTRL_BIT],
                                pair_s[tgc_pkg::IDLE_CTRL_BIT]};
        end
    end

    // Checks in the management domain
    a_soft_self_clear: assert property (@(posedge mdc) disable iff (!mdc_rst_n)
        soft_reset_q |=> !soft_reset_q)
        else $error("soft reset bit did not clear itself");
    a_soft_keeps_regs: assert property (@(posedge mdc) disable iff (!mdc_rst_n)
        soft_reset_q |-> $stable(pair_q[0]) && $stable(pair_q[3]))
        else $error("soft reset disturbed management registers");
    a_reserved_zero: assert property (@(posedge mdc) disable iff (!mdc_rst_n)
        (rdata_d & ~(tgc_pkg::GLOBAL_WMASK | 16'h0008) & {16{mgmt.addr == tgc_pkg::REG_GLOBAL}})
        == 16'h0000 && (global_q & ~tgc_pkg::GLOBAL_WMASK) == 16'h0000)
        else $error("reserved global bits not zero");
    a_pair_defaults: assert property (@(posedge mdc)
        !mdc_rst_n |=> pair_q[0][11:10] == tgc_pkg::EMPH_HIGH && pair_q[3][11:10] == 2'h3)
        else $error("pair emphasis reset not high");
    a_idle_defaults: assert property (@(posedge mdc)
        !mdc_rst_n |=> pair_q[0][8:0] == 9'h1BC && pair_q[1][8:0] == 9'h050 &&
        pair_q[2][8:0] == 9'h1BC && pair_q[3][8:0] == 9'h050)
        else $error("idle character reset values wrong");

    // Checks in the core domain
    a_tx_clock_or: assert property (@(posedge clk) disable iff (!rst_n)
        pins_s[tgc_pkg::PIN_TX_CLK] |=> tx_clock_individual_sel)
        else $error("terminal did not force individual clocking");
    a_out_enable_and: assert property (@(posedge clk) disable iff (!rst_n)
        !pins_s[tgc_pkg::PIN_ENABLE] |=> !parallel_out_enable)
        else $error("outputs enabled with enable terminal low");
    a_mode_override: assert property (@(posedge clk) disable iff (!rst_n)
        global_s[tgc_pkg::BIT_MODE_OVERRIDE] |=> interface_mode == $past(global_s[5:4]))
        else $error("mode override not taken");
    a_soft_pulse: assert property (@(posedge clk) disable iff (!rst_n)
        soft_pulse |=> datapath_reset ##1 !datapath_reset || soft_pulse)
        else $error("soft reset pulse not one cycle");
    a_emph_override: assert property (@(posedge clk) disable iff (!rst_n)
        !pair_s[tgc_pkg::BIT_EDGE_OVR] |=> emphasis_level[1:0] == $past(pins_s[7:6]))
        else $error("global emphasis not used without override");
endmodule

// ### verif/tgc_sta_model.sv
/* Station management model: makes mdc and sends clause-22 frames.
   Assumes a pull-up on the data line and the device at port 1. */
module tgc_sta_model (
    // Link
    output logic mdc,
    output logic line,
    // Device drive
    input wire logic dev_d,
    input wire logic dev_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    logic m_d = 1'b1;
    logic m_oe = 1'b0;
    // Shared line, pulled up when nobody drives
    assign line = dev_oe ? dev_d : (m_oe ? m_d : 1'b1);
    // Management clock, 64 ns
    initial begin
        mdc = 1'b0;
        forever #32 mdc = ~mdc;
    end
    // one frame at a time, each bit held to its sampling edge
    task automatic xfer(input logic [1:0] op, input logic [4:0] ra, input logic [15:0] wd,
        output logic [15:0] rd);
        logic [63:0] f;
        f = {32'hFFFFFFFF, 2'h1, op, 5'h01, ra, 2'h2, wd};
        for (int i = 63; i >= 0; i--) begin
            @(negedge mdc);
            m_d <= f[i];
            m_oe <= !(op == 2'h2 && i < 18);
            @(posedge mdc);
            if (i < 16) rd[i] = line;
        end
        @(negedge mdc) m_oe <= 1'b0;
    endtask
endmodule

// ### verif/tb_tgc_top.sv
/* Self-checking bench for the global control register bank.
   Assumes the station model at port 1 and slow terminal levels. */
module tb_tgc_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst_n, mdc, line, mdio_o, mdio_oe, dpr;
    logic [7:0] pins = 8'h04;
    logic [6:0] ctl;
    logic [7:0] emph;
    logic [3:0] ovr, idc;
    logic [8:0] idl [4];
    logic [15:0] wd, rd;
    logic [15:0] w [5] = '{16'h4380, 16'h0DBC, 16'h0C50, 16'h0DBC, 16'h0C50};
    int hits;
    int err_count = 0;
    int samples_checked = 0;
    tgc_sta_model sta (.mdc(mdc), .line(line), .dev_d(mdio_o), .dev_oe(mdio_oe));
    tgc_top DUT (.clk(clk), .rst_n(rst_n), .mdc(mdc), .mdio_i(line), .mdio_o(mdio_o),
        .mdio_oe(mdio_oe), .port_address(5'h01), .tx_clock_select_pin(pins[0]),
        .violation_report_pin(pins[1]), .device_enable_pin(pins[2]), .line_code_pin(pins[3]),
        .mode_pin(pins[5:4]), .global_emphasis_pin(pins[7:6]),
        .tx_clock_individual_sel(ctl[6]), .violation_report_enable(ctl[5]),
        .parallel_out_enable(ctl[4]), .comma_detect_enable(ctl[3]),
        .line_code_enable(ctl[2]), .interface_mode(ctl[1:0]), .datapath_reset(dpr),
        .emphasis_level(emph), .emphasis_override(ovr), .idle_char_first(idl[0]),
        .idle_char_second(idl[1]), .idle_char_first_alt(idl[2]),
        .idle_char_second_alt(idl[3]), .idle_is_control(idc));
    // Core clock, 10 ns
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    function automatic logic [15:0] exp_ctl(logic [15:0] g, logic [7:0] p);
        return {9'h000, g[15] | p[0], g[14] | p[1], g[9] & p[2], g[8], g[7] | p[3],
            g[6] ? g[5:4] : p[5:4]};
    endfunction
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        samples_checked++;
        if (g !== e) begin
            err_count++;
            $display("CHECK FAILED %s exp %h got %h", nm, e, g);
        end
    endtask
    // Read all registers back, then compare the core outputs
    task automatic check_all(input string nm);
        logic [15:0] v;
        for (int r = 0; r < 5; r++) begin
            sta.xfer(2'h2, 5'h11 + 5'(r), 16'h0000, v);
            chk("readback", w[r], v);
        end
        repeat (30) @(negedge clk);
        chk("control", exp_ctl(w[0], pins), {9'h000, ctl});
        for (int k = 0; k < 4; k++) begin
            chk("emphasis", {13'h0000, w[k+1][9], w[k+1][9] ? w[k+1][11:10] : pins[7:6]},
                {13'h0000, ovr[k], emph[2*k +: 2]});
            chk("idle", {7'h00, w[k+1][8:0]}, {7'h00, idl[k]});
            chk("ctrl flag", {15'h0000, w[k+1][8]}, {15'h0000, idc[k]});
        end
        $display("test %s done", nm);
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // Watchdog
    initial begin
        #600us;
        err_count++;
        test_done();
    end
    // Main sequence
    initial begin
        rst_n = 1'b0;
        void'($urandom(27016));
        repeat (40) @(negedge clk);
        rst_n = 1'b1;
        repeat (40) @(negedge clk);
        check_all("reset");
        for (int n = 0; n < 6; n++) begin
            for (int r = 0; r < 6; r++) begin
                wd = (n == 0) ? 16'hFFFF : (n == 1) ? 16'h0000 : 16'($urandom);
                sta.xfer(2'h1, 5'h11 + 5'(r), wd, rd);
                if (r < 5) w[r] = wd & (r == 0 ? tgc_pkg::GLOBAL_WMASK : tgc_pkg::PAIR_WMASK);
            end
            sta.xfer(2'h2, 5'h16, 16'h0000, rd);
            chk("unmapped", 16'h0000, rd);
            @(negedge clk) pins = 8'($urandom);
            check_all("random");
        end
        hits = 0;
        fork
            sta.xfer(2'h1, 5'h11, w[0] | 16'h0008, rd);
            repeat (600) @(negedge clk) hits += int'(dpr);
        join
        chk("reset pulse", 16'h0001, 16'(hits));
        check_all("soft reset");
        test_done();
    end
endmodule
